/* File: verilog/qsw_sram_port.sv */
// Top of the burst SRAM port model: arbitration, write bursts, read bursts, echo strobes.
// Assumes the controller runs on the same clock and aligns to the slot phase
// shown by echo_strobe; clk_run low models stopped input clocks.
`timescale 1ns/10ps
`default_nettype none
// Function
// - Write starts when write select is low at a primary edge; address latched.
// - Four words captured on the four edges after the next one, then committed together.
// - Write request on the primary edge right after a write start is ignored.
// - Deselected write port finishes its burst, then ignores inputs.
// - Byte selects sampled with each word; only low selects store bytes.
// - High select keeps stored byte; bit0 covers bits 8:0, bit1 bits 17:9.
// - All selects high on an edge writes nothing for that word.
// - Byte selects may change per edge and each edge is honoured.
// - Read and write bursts may overlap on any location, but a read start blocks a write start on the same edge.
// - Read after write to same address returns newest, forwarded data.
// - Both selected: read wins unless a read started last cycle.
// - Selects sampled on primary edges only; pending bursts complete.
// - Two free-running echo strobes follow primary and inverted clocks.
// - Valid flag is timed like data and leads first word by half cycle.
// - PLL counts as locked 20 us after a stable clock.
// - Clocks stopped at least 30 ns reset the PLL lock.
// - Bypass low turns off PLL and gives one-cycle read latency.
// - Read words driven on t+2 and t+3 primary and inverted edges.
// - Ports come up deselected with read outputs not driven.
// - Stopped clocks keep all port state but drop PLL lock; controller should hold clocks high.
// - Read on the primary edge right after a read start is ignored.
// - Deselected read port finishes its burst then stops driving after a primary edge.
module qsw_sram_port #(
   parameter int ADDR_W   = qsw_pkg::ADDR_W_DEF,
   parameter int LOCK_CYC = qsw_pkg::LOCK_CYCLES
) (
   input  wire logic                                 clock,
   input  wire logic                                 rst_n,
   input  wire logic                                 clk_run,
   input  wire logic                                 pll_bypass_n,
   input  wire qsw_pkg::qsw_sel_t                    port_select,
   input  wire logic [ADDR_W-1:0]                    address,
   input  wire logic [qsw_pkg::WORD_W-1:0]           write_data,
   input  wire logic [qsw_pkg::NBYTE-1:0]            byte_write_select_n,
   output logic [qsw_pkg::WORD_W-1:0]                read_data,
   output logic                                      read_data_oe,
   output logic                                      output_valid_flag,
   output logic                                      echo_strobe,
   output logic                                      echo_strobe_n,
   output logic                                      pll_ready
);
   import qsw_pkg::*;

   typedef struct packed {
      logic                              ph;
      logic                              echo;
      logic                              echo_n;
      logic                              last_rd;
      logic                              last_wr;
      logic [ADDR_W-1:0]                 wr_start_addr;
      logic [PIPE_D-1:0]                 pv;
      logic [PIPE_D-1:0][ADDR_W-1:0]     pa;
      logic [PIPE_D-1:0]                 pf;
      logic                              ob_act;
      logic [1:0]                        ob_beat;
      logic [ADDR_W-1:0]                 ob_addr;
      logic                              ob_fwd;
      logic [WORD_W-1:0]                 rdata;
      logic                              oe;
      logic                              valid;
      logic                              wb_act;
      logic [2:0]                        wb_slot;
      logic [ADDR_W-1:0]                 wb_addr;
      logic                              wq_act;
      logic [ADDR_W-1:0]                 wq_addr;
      qsw_beat_t [BEATS-1:0]             wbuf;
   } qsw_state_t;

   qsw_state_t                       st;
   qsw_state_t                       next_st;
   logic                             ready;
   logic                             bypass;
   logic                             rd_go;
   logic                             wr_go;
   logic                             launch;
   logic                             fwd;
   logic [1:0]                       beat;
   logic [ADDR_W-1:0]                rd_addr;
   logic [BEATS-1:0][WORD_W-1:0]     rd_word;
   logic [WORD_W-1:0]                merged;
   qsw_beat_t                        in_beat;
   qsw_beat_t [BEATS-1:0]            commit_word;
   logic                             commit_en;
   int                               launch_idx;
   int                               pre_idx;

   qsw_pll_lock #(
      .LOCK_CYC (LOCK_CYC)
   ) u_pll (
      .clock        (clock),
      .rst_n        (rst_n),
      .clk_run      (clk_run),
      .pll_bypass_n (pll_bypass_n),
      .pll_ready    (ready),
      .bypass_mode  (bypass)
   );

   qsw_bank_array #(
      .ADDR_W (ADDR_W)
   ) u_banks (
      .clock   (clock),
      .wr_en   (commit_en),
      .wr_addr (st.wb_addr),
      .wr_word (commit_word),
      .rd_addr (rd_addr),
      .rd_word (rd_word)
   );

   always_comb begin
      // Latency follows the live bypass level; changing it mid-burst is not supported
      launch_idx = SLOTS_PER_CYCLE * (bypass ? LAT_BYP : LAT_PLL) - 1;
      pre_idx    = launch_idx - 1;

      // Starts only on primary edges, and only once the clocking is usable
      rd_go = clk_run && ready && (st.ph == PH_PRI)
              && !port_select.read_port_select_n && !st.last_rd;
      wr_go = clk_run && ready && (st.ph == PH_PRI)
              && !port_select.write_port_select_n && !st.last_wr && !rd_go;

      launch  = clk_run && st.pv[launch_idx];
      rd_addr = launch ? st.pa[launch_idx] : st.ob_addr;
      beat    = launch ? BEAT_FIRST : st.ob_beat;
      fwd     = launch ? st.pf[launch_idx] : st.ob_fwd;

      // Bytes of a write still in the buffer override the array
      for (int y = 0; y < NBYTE; y++) begin
         merged[y*BYTE_W +: BYTE_W] = (fwd && st.wbuf[beat].byte_en[y])
                                      ? st.wbuf[beat].data[y*BYTE_W +: BYTE_W]
                                      : rd_word[beat][y*BYTE_W +: BYTE_W];
      end

      in_beat.byte_en = ~byte_write_select_n;
      in_beat.data    = write_data;
      commit_en       = clk_run && st.wb_act && (st.wb_slot == WSLOT_LAST);
      for (int k = 0; k < BEATS; k++) begin
         commit_word[k] = (k == BEATS - 1) ? in_beat : st.wbuf[k];
      end
   end

   always_comb begin
      next_st = st;
      // Nothing moves while the input clocks are stopped
      if (clk_run) begin
         next_st.ph     = ~st.ph;
         next_st.echo   = (st.ph == PH_PRI);
         next_st.echo_n = (st.ph == PH_INV);

         if (st.ph == PH_PRI) begin
            next_st.last_rd = rd_go;
            next_st.last_wr = wr_go;
         end

         // Read start pipeline, one stage per slot
         next_st.pv = {st.pv[PIPE_D-2:0], rd_go};
         next_st.pa = {st.pa[PIPE_D-2:0], address};
         next_st.pf = {st.pf[PIPE_D-2:0],
                       (st.last_wr && (st.wr_start_addr == address))};

         // Read burst output, one word per slot
         if (launch) begin
            next_st.ob_act  = 1'b1;
            next_st.ob_beat = BEAT_FIRST + 2'h1;
            next_st.ob_addr = st.pa[launch_idx];
            next_st.ob_fwd  = st.pf[launch_idx];
         end else if (st.ob_act) begin
            next_st.ob_beat = st.ob_beat + 2'h1;
            if (st.ob_beat == BEAT_LAST) begin
               next_st.ob_act = 1'b0;
            end
         end
         next_st.oe    = launch || st.ob_act;
         next_st.rdata = (launch || st.ob_act) ? merged : '0;
         // Valid runs one slot ahead of the data words
         next_st.valid = st.pv[pre_idx] || launch
                         || (st.ob_act && (st.ob_beat != BEAT_LAST));

         // Write burst capture; a new start overlaps the tail of the current burst
         if (st.wb_act) begin
            if (st.wb_slot != WSLOT_WAIT) begin
               next_st.wbuf[st.wb_slot - WSLOT_FIRST] = in_beat;
            end
            if (st.wb_slot == WSLOT_LAST) begin
               next_st.wb_act  = st.wq_act;
               next_st.wb_addr = st.wq_addr;
               next_st.wb_slot = WSLOT_FIRST;
               next_st.wq_act  = 1'b0;
            end else begin
               next_st.wb_slot = st.wb_slot + 3'h1;
            end
         end
         if (wr_go) begin
            next_st.wr_start_addr = address;
            if (st.wb_act) begin
               next_st.wq_act  = 1'b1;
               next_st.wq_addr = address;
            end else begin
               next_st.wb_act  = 1'b1;
               next_st.wb_addr = address;
               next_st.wb_slot = WSLOT_WAIT;
            end
         end
      end
   end

   // Reset leaves both ports idle and the read outputs undriven
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign read_data         = st.rdata;
   assign read_data_oe      = st.oe;
   assign output_valid_flag = st.valid;
   assign echo_strobe       = st.echo;
   assign echo_strobe_n     = st.echo_n;
   assign pll_ready         = ready;
endmodule
`default_nettype wire

/* File: verilog/qsw_pkg.sv */
// Constants, timing counts and carrier types of the burst SRAM port model.
// Assumes one 20 MHz clock; each input-clock cycle is two clock slots.
package qsw_pkg;
   localparam int WORD_W          = 18;
   localparam int BYTE_W          = 9;
   localparam int NBYTE           = WORD_W / BYTE_W;
   localparam int BEATS           = 4;
   localparam int ADDR_W_DEF      = 8;
   localparam int PIPE_D          = 4;
   localparam int SLOTS_PER_CYCLE = 2;
   localparam int LAT_PLL         = 2;
   localparam int LAT_BYP         = 1;

   localparam int CLK_PERIOD_NS   = 50;
   localparam int LOCK_TIME_US    = 20;
   localparam int LOCK_CYCLES     = (LOCK_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STOP_TIME_NS    = 30;
   localparam int STOP_CYC_RAW    = (STOP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STOP_CYCLES     = (STOP_CYC_RAW < 1) ? 1 : STOP_CYC_RAW;
   localparam int LOCK_CNT_W      = 16;
   localparam int STOP_CNT_W      = 4;

   localparam logic       PH_PRI      = 1'b0;
   localparam logic       PH_INV      = 1'b1;
   localparam logic [2:0] WSLOT_WAIT  = 3'h0;
   localparam logic [2:0] WSLOT_FIRST = 3'h1;
   localparam logic [2:0] WSLOT_LAST  = 3'h4;
   localparam logic [1:0] BEAT_FIRST  = 2'h0;
   localparam logic [1:0] BEAT_LAST   = 2'h3;

   typedef struct packed {
      logic [NBYTE-1:0]  byte_en;
      logic [WORD_W-1:0] data;
   } qsw_beat_t;

   typedef struct packed {
      logic read_port_select_n;
      logic write_port_select_n;
   } qsw_sel_t;
endpackage

/* File: verilog/qsw_bank_array.sv */
// Four word banks, one per burst position, with per-byte write enables.
// Assumes the caller presents a whole four-word burst in one commit cycle.
`timescale 1ns/10ps
`default_nettype none
module qsw_bank_array #(
   parameter int ADDR_W = qsw_pkg::ADDR_W_DEF
) (
   input  wire logic                                           clock,
   input  wire logic                                           wr_en,
   input  wire logic [ADDR_W-1:0]                              wr_addr,
   input  wire qsw_pkg::qsw_beat_t [qsw_pkg::BEATS-1:0]        wr_word,
   input  wire logic [ADDR_W-1:0]                              rd_addr,
   output logic [qsw_pkg::BEATS-1:0][qsw_pkg::WORD_W-1:0]      rd_word
);
   import qsw_pkg::*;
   localparam int DEPTH = 1 << ADDR_W;

   genvar b;
   generate
      for (b = 0; b < BEATS; b++) begin : g_bank
         logic [WORD_W-1:0] mem [DEPTH];
         always_ff @(posedge clock) begin
            for (int y = 0; y < NBYTE; y++) begin
               // Masked bytes keep their old contents
               if (wr_en && wr_word[b].byte_en[y]) begin
                  mem[wr_addr][y*BYTE_W +: BYTE_W] <= wr_word[b].data[y*BYTE_W +: BYTE_W];
               end
            end
         end
         assign rd_word[b] = mem[rd_addr];
      end
   endgenerate
endmodule
`default_nettype wire

/* File: verilog/qsw_pll_lock.sv */
// Lock timer standing in for the internal PLL, plus bypass pin capture.
// Assumes clk_run comes from same-clock logic; the bypass pin is asynchronous.
`timescale 1ns/10ps
`default_nettype none
module qsw_pll_lock #(
   parameter int LOCK_CYC = qsw_pkg::LOCK_CYCLES
) (
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic clk_run,
   input  wire logic pll_bypass_n,
   output logic      pll_ready,
   output logic      bypass_mode
);
   import qsw_pkg::*;

   typedef struct packed {
      logic                  byp_s1;
      logic                  byp_s2;
      logic                  locked;
      logic                  ready;
      logic [LOCK_CNT_W-1:0] lock_cnt;
      logic [STOP_CNT_W-1:0] stop_cnt;
   } qsw_pll_state_t;

   qsw_pll_state_t st;
   qsw_pll_state_t next_st;

   always_comb begin
      next_st = st;
      next_st.byp_s1 = ~pll_bypass_n;
      next_st.byp_s2 = st.byp_s1;
      if (!clk_run) begin
         // A long enough stall drops lock and restarts the lock delay
         if (st.stop_cnt < STOP_CNT_W'(STOP_CYCLES)) begin
            next_st.stop_cnt = st.stop_cnt + STOP_CNT_W'(1);
         end
         if (st.stop_cnt + STOP_CNT_W'(1) >= STOP_CNT_W'(STOP_CYCLES)) begin
            next_st.locked   = 1'b0;
            next_st.lock_cnt = '0;
         end
      end else begin
         next_st.stop_cnt = '0;
         if (!st.locked) begin
            if (st.lock_cnt == LOCK_CNT_W'(LOCK_CYC - 1)) begin
               next_st.locked = 1'b1;
            end else begin
               next_st.lock_cnt = st.lock_cnt + LOCK_CNT_W'(1);
            end
         end
      end
      next_st.ready = next_st.locked | st.byp_s2;
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign pll_ready   = st.ready;
   assign bypass_mode = st.byp_s2;
endmodule
`default_nettype wire

/* File: bench/qsw_sram_port_assertions.sv */
// Checker for the burst SRAM port top; watches its ports only.
// Assumes one clock; echo_strobe low means the coming edge is a primary edge.
`timescale 1ns/10ps
`default_nettype none
module qsw_sram_port_assertions #(
   parameter int LOCK_CYC = qsw_pkg::LOCK_CYCLES
) (
   input wire logic                       clock,
   input wire logic                       rst_n,
   input wire logic                       clk_run,
   input wire logic                       pll_bypass_n,
   input wire qsw_pkg::qsw_sel_t          port_select,
   input wire logic [qsw_pkg::WORD_W-1:0] read_data,
   input wire logic                       read_data_oe,
   input wire logic                       output_valid_flag,
   input wire logic                       echo_strobe,
   input wire logic                       pll_ready
);
   import qsw_pkg::*;
   logic        rd_prev;
   logic        rd_go;
   logic [15:0] run_cnt;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // Reads always win a primary edge unless one was taken on the previous one
   assign rd_go = clk_run && !echo_strobe && pll_ready
                  && !port_select.read_port_select_n && !rd_prev;
   always_ff @(posedge clock) begin
      if (!rst_n)
         rd_prev <= 1'b0;
      else if (clk_run && !echo_strobe)
         rd_prev <= rd_go;
   end
   always_ff @(posedge clock) begin
      if (!rst_n || !clk_run)
         run_cnt <= 16'h0;
      else if (run_cnt != 16'hFFFF)
         run_cnt <= run_cnt + 16'h1;
   end
   a_echo_toggle: assert property (clk_run |=> echo_strobe != $past(echo_strobe))
      else $error("echo strobe did not toggle");
   a_stop_freeze: assert property (!clk_run |=> $stable(echo_strobe) && $stable(read_data))
      else $error("state moved while clocks stopped");
   a_oe_idle: assert property (!read_data_oe |-> read_data == '0)
      else $error("read data not idle");
   a_valid_lead: assert property ($rose(read_data_oe) |-> $past(output_valid_flag))
      else $error("valid flag did not lead first word");
   a_rd_pll: assert property (rd_go && pll_bypass_n && $past(pll_bypass_n, 3)
      |=> ##3 output_valid_flag ##1 read_data_oe [*4])
      else $error("read timing wrong with pll");
   a_rd_bypass: assert property (rd_go && !pll_bypass_n && !$past(pll_bypass_n, 3)
      |=> ##1 output_valid_flag ##1 read_data_oe [*4])
      else $error("read timing wrong in bypass");
   a_pll_drop: assert property (!clk_run && pll_bypass_n |-> ##[1:3] !pll_ready)
      else $error("lock kept while clocks stopped");
   a_lock_time: assert property ($rose(pll_ready) && pll_bypass_n && $past(pll_bypass_n, 3)
      |-> int'(run_cnt) >= LOCK_CYC - 1 && int'(run_cnt) <= LOCK_CYC + 2)
      else $error("lock delay wrong");
endmodule
bind qsw_sram_port qsw_sram_port_assertions #(.LOCK_CYC(LOCK_CYC)) u_chk (
   .clock(clock), .rst_n(rst_n), .clk_run(clk_run), .pll_bypass_n(pll_bypass_n),
   .port_select(port_select), .read_data(read_data), .read_data_oe(read_data_oe),
   .output_valid_flag(output_valid_flag), .echo_strobe(echo_strobe), .pll_ready(pll_ready));
`default_nettype wire

/* File: bench/qsw_ctrl_model.sv */
// Memory controller model: starts bursts on primary edges, drives write words.
// Assumes echo_strobe low at a falling edge marks a coming primary edge.
`timescale 1ns/10ps
`default_nettype none
module qsw_ctrl_model #(
   parameter int ADDR_W = qsw_pkg::ADDR_W_DEF
) (
   input  wire logic                       clock,
   input  wire logic                       echo_strobe,
   output qsw_pkg::qsw_sel_t               port_select,
   output logic [ADDR_W-1:0]               address,
   output logic [qsw_pkg::WORD_W-1:0]      write_data,
   output logic [qsw_pkg::NBYTE-1:0]       byte_write_select_n
);
   import qsw_pkg::*;
   // Idle masks low so a wrongly taken write would corrupt memory
   initial begin
      port_select = 2'h3;
      address = '0;
      write_data = 18'h0;
      byte_write_select_n = 2'h0;
   end
   task automatic prim();
      do @(negedge clock); while (echo_strobe !== 1'b0);
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic both);
      prim();
      port_select.read_port_select_n <= 1'b0;
      if (both)
         port_select.write_port_select_n <= 1'b0;
      address <= a;
      @(negedge clock);
      port_select <= 2'h3;
      address <= ~a;
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [71:0] w, input logic [7:0] m,
                     input logic again, input logic [ADDR_W-1:0] a2);
      prim();
      port_select.write_port_select_n <= 1'b0;
      address <= a;
      @(negedge clock);
      port_select.write_port_select_n <= 1'b1;
      address <= ~a;
      for (int k = 0; k < 4; k++) begin
         @(negedge clock);
         write_data <= w[18*k +: 18];
         byte_write_select_n <= m[2*k +: 2];
         if (again && k < 2) begin
            port_select.write_port_select_n <= k[0];
            address <= k[0] ? ~a2 : a2;
         end
      end
      @(negedge clock);
      write_data <= ~w[71:54];
      byte_write_select_n <= 2'h0;
   endtask
endmodule
`default_nettype wire

/* File: bench/tb_qsw_sram_port.sv */
// Self-checking bench for the burst SRAM port top and its controller model.
// Assumes one 20 MHz clock; the lock count is cut to 8 cycles.
`timescale 1ns/10ps
`default_nettype none
module tb_qsw_sram_port;
   import qsw_pkg::*;
   logic                  clock;
   logic                  rst_n;
   logic                  clk_run;
   logic                  pll_bypass_n;
   qsw_sel_t              port_select;
   logic [ADDR_W_DEF-1:0] address;
   logic [WORD_W-1:0]     write_data;
   logic [NBYTE-1:0]      byte_write_select_n;
   logic [WORD_W-1:0]     read_data;
   logic                  read_data_oe;
   logic                  output_valid_flag;
   logic                  echo_strobe;
   logic                  echo_strobe_n;
   logic                  pll_ready;
   logic [71:0]           mem [0:255];
   int                    bad_count = 0;
   int                    tests_run = 0;
   int                    cycles = 0;
   qsw_sram_port #(.ADDR_W(ADDR_W_DEF), .LOCK_CYC(8)) u_dut (
      .clock(clock), .rst_n(rst_n), .clk_run(clk_run), .pll_bypass_n(pll_bypass_n),
      .port_select(port_select), .address(address), .write_data(write_data),
      .byte_write_select_n(byte_write_select_n), .read_data(read_data),
      .read_data_oe(read_data_oe), .output_valid_flag(output_valid_flag),
      .echo_strobe(echo_strobe), .echo_strobe_n(echo_strobe_n), .pll_ready(pll_ready));
   qsw_ctrl_model #(.ADDR_W(ADDR_W_DEF)) u_ctrl (
      .clock(clock), .echo_strobe(echo_strobe), .port_select(port_select),
      .address(address), .write_data(write_data), .byte_write_select_n(byte_write_select_n));
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   task automatic final_report();
      $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         bad_count++;
         final_report();
      end
   end
   task automatic cmp(input logic [17:0] got, input logic [17:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wait_ready();
      for (int i = 0; i < 40 && pll_ready !== 1'b1; i++)
         @(negedge clock);
      cmp({17'h0, pll_ready}, 18'h1);
   endtask
   // Shadow updated before the burst so an overlapping read sees new data
   task automatic wr_do(input logic [7:0] a, input logic [71:0] w, input logic [7:0] m,
                        input logic again, input logic [7:0] a2);
      for (int i = 0; i < 8; i++)
         if (!m[i]) mem[a][9*i +: 9] = w[9*i +: 9];
      u_ctrl.wr(a, w, m, again, a2);
   endtask
   task automatic rd_chk(input logic [7:0] a, input int lat, input logic both);
      logic [71:0] e;
      e = mem[a];
      u_ctrl.rd(a, both);
      repeat (2*lat - 1) @(negedge clock);
      cmp({16'h0, output_valid_flag, read_data_oe}, 18'h2);
      for (int k = 0; k < 4; k++) begin
         @(negedge clock);
         cmp(read_data, e[18*k +: 18]);
      end
      @(negedge clock);
      cmp({16'h0, read_data_oe, output_valid_flag}, 18'h0);
   endtask
   task automatic t_reset();
      cmp({16'h0, read_data_oe, output_valid_flag}, 18'h0);
      cmp(read_data, 18'h0);
      wait_ready();
      $display("test reset done");
   endtask
   task automatic t_write_read();
      wr_do(8'h10, 72'h123456789ABCDEF012, 8'h00, 1'b0, 8'h10);
      rd_chk(8'h10, 2, 1'b0);
      wr_do(8'h10, 72'hFEDCBA9876543210AB, 8'h39, 1'b0, 8'h10);
      rd_chk(8'h10, 2, 1'b0);
      $display("test write read done");
   endtask
   task automatic t_refuse();
      wr_do(8'h20, 72'h0A5A5A5A5A5A5A5A5A, 8'h00, 1'b0, 8'h20);
      wr_do(8'h30, 72'h3C3C3C3C3C3C3C3C3C, 8'h00, 1'b1, 8'h20);
      rd_chk(8'h20, 2, 1'b0);
      rd_chk(8'h30, 2, 1'b0);
      $display("test refuse done");
   endtask
   task automatic t_forward();
      u_ctrl.prim();
      fork
         wr_do(8'h40, 72'h2468ACE013579BDF11, 8'h00, 1'b0, 8'h40);
         begin
            repeat (2) @(negedge clock);
            rd_chk(8'h40, 2, 1'b0);
         end
      join
      $display("test forward done");
   endtask
   task automatic t_both();
      rd_chk(8'h10, 2, 1'b1);
      rd_chk(8'h10, 2, 1'b0);
      $display("test both selects done");
   endtask
   task automatic t_stop();
      logic e;
      @(negedge clock);
      e = echo_strobe;
      clk_run = 1'b0;
      repeat (3) @(negedge clock);
      cmp({16'h0, echo_strobe, pll_ready}, {16'h0, e, 1'b0});
      cmp({16'h0, echo_strobe, echo_strobe_n}, {16'h0, e, ~e});
      clk_run = 1'b1;
      wait_ready();
      rd_chk(8'h20, 2, 1'b0);
      $display("test clock stop done");
   endtask
   task automatic t_bypass();
      pll_bypass_n = 1'b0;
      repeat (6) @(negedge clock);
      cmp({17'h0, pll_ready}, 18'h1);
      rd_chk(8'h10, 1, 1'b0);
      $display("test bypass done");
   endtask
   initial begin
      rst_n = 1'b0;
      clk_run = 1'b1;
      pll_bypass_n = 1'b1;
      repeat (4) @(negedge clock);
      rst_n = 1'b1;
      t_reset();
      t_write_read();
      t_refuse();
      t_forward();
      t_both();
      t_stop();
      t_bypass();
      final_report();
   end
endmodule
`default_nettype wire
